// >>> t1l_pma_control_regs.sv
// Summary of operation
// - A role bit of 1 at bit 14 of the BASE-T1 control makes the device master, 0 makes it slave.
// - The software role bit applies only with autonegotiation off; otherwise the negotiated role is used.
// - The type field in bits 3:0 decodes 0010 T1L, 0011 T1S, 0001 1000BASE-T, 0000 100BASE-T; 1xxx and 01xx are reserved.
// - The type field applies only with autonegotiation off and forced configuration on; otherwise the negotiated type is used.
// - Transmit-disable bit 14 of the long-reach control suppresses transmit output when 1.
// - Amplitude bit 12 selects 2.4 V p-p when 1 and 1.0 V p-p when 0.
// - The software amplitude applies only with autonegotiation off; otherwise the negotiated amplitude is used.
// - Loopback bit 0 returns transmit data on the receive path when 1.
`timescale 1ns/1ps
`default_nettype none
module t1l_pma_control_regs
	import t1l_pma_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`WB_ADR_W-1:0] wb_adr_i,
	input wire logic [`WB_SEL_W-1:0] wb_sel_i,
	input wire logic [`WB_DAT_W-1:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [`WB_DAT_W-1:0] wb_dat_o,
	input wire logic strap_master_i,
	input wire logic strap_high_amplitude_i,
	input wire logic autoneg_enable_i,
	input wire logic forced_link_config_i,
	input wire logic an_link_master_i,
	input wire logic an_high_amplitude_i,
	input wire logic [`TYPE_W-1:0] an_phy_type_i,
	input wire logic [`SYM_W-1:0] tx_symbol_i,
	input wire logic [`SYM_W-1:0] rx_line_symbol_i,
	output logic link_master_o,
	output logic [`TYPE_W-1:0] phy_type_o,
	output logic phy_type_reserved_o,
	output logic transmit_high_amplitude_o,
	output logic transmit_output_disable_o,
	output logic energy_efficient_enable_o,
	output logic pma_local_loopback_enable_o,
	output logic [`SYM_W-1:0] tx_line_symbol_o,
	output logic tx_line_enable_o,
	output logic [`SYM_W-1:0] rx_symbol_o
);
	typedef struct packed {
		bus_state_type state;
		logic [`REG_W-1:0] base_t1_pma_pmd_control;
		logic [`REG_W-1:0] long_reach_pma_control;
		logic bad_type_written;
		logic ack;
		logic [`WB_DAT_W-1:0] rdata;
	} regs_type;

	localparam regs_type REGS_RESET = '{
		state: ST_RESET,
		base_t1_pma_pmd_control: `BT1_CTRL_RESET,
		long_reach_pma_control: `LR_CTRL_RESET,
		bad_type_written: 1'b0,
		ack: 1'b0,
		rdata: '0
	};

	regs_type r;
	regs_type n;

	pma_cfg_if cfg();

	logic [`INDEX_W-1:0] index;
	logic request;
	logic [`REG_W-1:0] wdata;
	logic [`REG_W-1:0] status_word;

	assign index = wb_adr_i[`WB_ADR_W-1:`INDEX_LSB];
	assign request = wb_cyc_i & wb_stb_i;
	assign wdata = wb_dat_i[`REG_W-1:0];

	// Resolved operating point as software sees it.
	always_comb begin
		status_word = '0;
		status_word[`ST_MASTER_BIT] = cfg.link_master;
		status_word[`ST_HIGH_AMP_BIT] = cfg.high_amplitude;
		status_word[`ST_TYPE_RSVD_BIT] = cfg.phy_type_reserved;
		status_word[`ST_BAD_TYPE_BIT] = r.bad_type_written;
		status_word[`ST_TYPE_LSB+`TYPE_W-1:`ST_TYPE_LSB] = cfg.phy_type;
		status_word[`ST_AUTONEG_BIT] = autoneg_enable_i;
		status_word[`ST_FORCED_BIT] = forced_link_config_i;
	end

	// Upper half of the data bus always reads as zero.
	function automatic logic [`WB_DAT_W-1:0] read_word(
		input logic [`INDEX_W-1:0] idx,
		input logic [`REG_W-1:0] bt1,
		input logic [`REG_W-1:0] lr,
		input logic [`REG_W-1:0] st);
		logic [`REG_W-1:0] v;
		v = '0;
		case (idx)
			`BT1_CTRL_INDEX: begin
				v = bt1;
			end
			`LR_CTRL_INDEX: begin
				v = lr;
			end
			`CFG_STATUS_INDEX: begin
				v = st;
			end
			default: begin
				v = '0;
			end
		endcase
		return {{(`WB_DAT_W-`REG_W){1'b0}}, v};
	endfunction

	always_comb begin
		logic [`TYPE_W-1:0] new_type;
		logic bad_set;
		logic bad_clear;
		new_type = wdata[`BT1_TYPE_MSB:`BT1_TYPE_LSB];
		bad_set = 1'b0;
		bad_clear = 1'b0;
		n = r;
		n.ack = 1'b0;
		// The self-clearing bit only ever holds a written 1 for one cycle.
		n.long_reach_pma_control[`LR_SELF_CLEAR_BIT] = 1'b0;
		case (r.state)
			ST_RESET: begin
				// Straps are caught on the first cycle after release, so
				// the reset itself only ever loads constants.
				n.base_t1_pma_pmd_control[`BT1_ROLE_BIT] = strap_master_i;
				n.long_reach_pma_control[`LR_HIGH_AMP_BIT] =
					strap_high_amplitude_i;
				n.state = ST_IDLE;
			end
			ST_IDLE: begin
				if (request) begin
					if (wb_we_i) begin
						case (index)
							`BT1_CTRL_INDEX: begin
								n.base_t1_pma_pmd_control = merge_write(
									r.base_t1_pma_pmd_control, wdata,
									wb_sel_i[1:0], `BT1_CTRL_WMASK);
								// Anything but the T1L code is flagged.
								if (wb_sel_i[0] &&
									new_type != `TYPE_10BASE_T1L) begin
									bad_set = 1'b1;
								end
							end
							`LR_CTRL_INDEX: begin
								n.long_reach_pma_control = merge_write(
									r.long_reach_pma_control, wdata,
									wb_sel_i[1:0], `LR_CTRL_WMASK);
							end
							`CFG_STATUS_INDEX: begin
								bad_clear = wb_sel_i[0] &
									wdata[`ST_BAD_TYPE_BIT];
							end
							default: begin
								bad_clear = 1'b0;
							end
						endcase
					end
					n.rdata = read_word(index, r.base_t1_pma_pmd_control,
						r.long_reach_pma_control, status_word);
					n.ack = 1'b1;
					n.state = ST_ACK;
				end
			end
			ST_ACK: begin
				n.state = ST_IDLE;
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase
		// A clear that meets a new bad write keeps the flag set.
		if (bad_clear) begin
			n.bad_type_written = 1'b0;
		end
		if (bad_set) begin
			n.bad_type_written = 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			r <= REGS_RESET;
		end else begin
			r <= n;
		end
	end

	pma_mode_resolver u_resolver (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.bt1_ctrl_i(r.base_t1_pma_pmd_control),
		.lr_ctrl_i(r.long_reach_pma_control),
		.autoneg_enable_i(autoneg_enable_i),
		.forced_link_config_i(forced_link_config_i),
		.an_link_master_i(an_link_master_i),
		.an_high_amplitude_i(an_high_amplitude_i),
		.an_phy_type_i(an_phy_type_i),
		.cfg(cfg.source)
	);

	pma_loopback_path u_path (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.cfg(cfg.sink),
		.tx_symbol_i(tx_symbol_i),
		.rx_line_symbol_i(rx_line_symbol_i),
		.tx_line_symbol_o(tx_line_symbol_o),
		.tx_line_enable_o(tx_line_enable_o),
		.rx_symbol_o(rx_symbol_o)
	);

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.rdata;
	assign link_master_o = cfg.link_master;
	assign phy_type_o = cfg.phy_type;
	assign phy_type_reserved_o = cfg.phy_type_reserved;
	assign transmit_high_amplitude_o = cfg.high_amplitude;
	assign transmit_output_disable_o = cfg.tx_disable;
	assign energy_efficient_enable_o = cfg.eee;
	assign pma_local_loopback_enable_o = cfg.loopback;
endmodule
`default_nettype wire

// >>> t1l_pma_defs.svh
`ifndef T1L_PMA_DEFS_SVH
`define T1L_PMA_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define BT1_CTRL_INDEX 14'h0834
`define LR_CTRL_INDEX 14'h08f6
`define CFG_STATUS_INDEX 14'h0900

`define WB_ADR_W 16
`define WB_DAT_W 32
`define WB_SEL_W 4
`define REG_W 16
`define INDEX_W 14
`define INDEX_LSB 2

`define BT1_CTRL_RESET 16'h8002
`define BT1_CTRL_WMASK 16'h400f
`define BT1_ROLE_BIT 14
`define BT1_TYPE_MSB 3
`define BT1_TYPE_LSB 0

`define LR_CTRL_RESET 16'h0000
`define LR_CTRL_WMASK 16'hdc01
`define LR_SELF_CLEAR_BIT 15
`define LR_TX_DISABLE_BIT 14
`define LR_HIGH_AMP_BIT 12
`define LR_EEE_BIT 10
`define LR_LOOPBACK_BIT 0

`define ST_MASTER_BIT 0
`define ST_HIGH_AMP_BIT 1
`define ST_TYPE_RSVD_BIT 2
`define ST_BAD_TYPE_BIT 3
`define ST_TYPE_LSB 4
`define ST_AUTONEG_BIT 8
`define ST_FORCED_BIT 9

`define TYPE_W 4
`define TYPE_100BASE_T 4'h0
`define TYPE_1000BASE_T 4'h1
`define TYPE_10BASE_T1L 4'h2
`define TYPE_10BASE_T1S 4'h3

`define SYM_W 2
`define SYM_IDLE 2'h0

`endif

// >>> t1l_pma_pkg.sv
package t1l_pma_pkg;
`include "t1l_pma_defs.svh"

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_IDLE = 2'b01,
		ST_ACK = 2'b11
	} bus_state_type;

	typedef enum logic [`TYPE_W-1:0] {
		PHY_100BASE_T = `TYPE_100BASE_T,
		PHY_1000BASE_T = `TYPE_1000BASE_T,
		PHY_10BASE_T1L = `TYPE_10BASE_T1L,
		PHY_10BASE_T1S = `TYPE_10BASE_T1S
	} phy_type_type;

	// Codes 1xxx and 01xx have no meaning.
	function automatic logic type_is_reserved(input logic [`TYPE_W-1:0] code);
		return code[3] | code[2];
	endfunction

	// Only bits in the mask take new data; the rest keep their value.
	function automatic logic [`REG_W-1:0] merge_write(
		input logic [`REG_W-1:0] old,
		input logic [`REG_W-1:0] wdata,
		input logic [1:0] lanes,
		input logic [`REG_W-1:0] wmask);
		logic [`REG_W-1:0] m;
		m = wmask & {{8{lanes[1]}}, {8{lanes[0]}}};
		return (old & ~m) | (wdata & m);
	endfunction
endpackage

// >>> pma_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pma_cfg_if;
	import t1l_pma_pkg::*;
	logic link_master;
	logic high_amplitude;
	logic tx_disable;
	logic loopback;
	logic eee;
	logic [`TYPE_W-1:0] phy_type;
	logic phy_type_reserved;

	modport source(output link_master, high_amplitude, tx_disable,
		loopback, eee, phy_type, phy_type_reserved);
	modport sink(input link_master, high_amplitude, tx_disable,
		loopback, eee, phy_type, phy_type_reserved);
endinterface
`default_nettype wire

// >>> pma_mode_resolver.sv
`timescale 1ns/1ps
`default_nettype none
module pma_mode_resolver
	import t1l_pma_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [`REG_W-1:0] bt1_ctrl_i,
	input wire logic [`REG_W-1:0] lr_ctrl_i,
	input wire logic autoneg_enable_i,
	input wire logic forced_link_config_i,
	input wire logic an_link_master_i,
	input wire logic an_high_amplitude_i,
	input wire logic [`TYPE_W-1:0] an_phy_type_i,
	pma_cfg_if.source cfg
);
	typedef struct packed {
		logic master;
		logic high_amp;
		logic tx_dis;
		logic lb;
		logic eee;
		logic [`TYPE_W-1:0] ptype;
		logic rsvd;
	} mode_type;

	localparam mode_type MODE_RESET = '{master: 1'b0, high_amp: 1'b0,
		tx_dis: 1'b0, lb: 1'b0, eee: 1'b0, ptype: `TYPE_10BASE_T1L,
		rsvd: 1'b0};

	mode_type r;
	mode_type n;

	always_comb begin
		n = r;
		if (autoneg_enable_i) begin
			n.master = an_link_master_i;
			n.high_amp = an_high_amplitude_i;
		end else begin
			n.master = bt1_ctrl_i[`BT1_ROLE_BIT];
			n.high_amp = lr_ctrl_i[`LR_HIGH_AMP_BIT];
		end
		if (!autoneg_enable_i && forced_link_config_i) begin
			n.ptype = bt1_ctrl_i[`BT1_TYPE_MSB:`BT1_TYPE_LSB];
		end else begin
			n.ptype = an_phy_type_i;
		end
		n.rsvd = type_is_reserved(n.ptype);
		n.tx_dis = lr_ctrl_i[`LR_TX_DISABLE_BIT];
		n.lb = lr_ctrl_i[`LR_LOOPBACK_BIT];
		n.eee = lr_ctrl_i[`LR_EEE_BIT];
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			r <= MODE_RESET;
		end else begin
			r <= n;
		end
	end

	assign cfg.link_master = r.master;
	assign cfg.high_amplitude = r.high_amp;
	assign cfg.tx_disable = r.tx_dis;
	assign cfg.loopback = r.lb;
	assign cfg.eee = r.eee;
	assign cfg.phy_type = r.ptype;
	assign cfg.phy_type_reserved = r.rsvd;
endmodule
`default_nettype wire

// >>> pma_loopback_path.sv
`timescale 1ns/1ps
`default_nettype none
module pma_loopback_path
	import t1l_pma_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	pma_cfg_if.sink cfg,
	input wire logic [`SYM_W-1:0] tx_symbol_i,
	input wire logic [`SYM_W-1:0] rx_line_symbol_i,
	output logic [`SYM_W-1:0] tx_line_symbol_o,
	output logic tx_line_enable_o,
	output logic [`SYM_W-1:0] rx_symbol_o
);
	typedef struct packed {
		logic [`SYM_W-1:0] tx_sym;
		logic tx_en;
		logic [`SYM_W-1:0] rx_sym;
	} path_type;

	localparam path_type PATH_RESET = '{tx_sym: `SYM_IDLE, tx_en: 1'b0,
		rx_sym: `SYM_IDLE};

	path_type r;
	path_type n;

	// Loopback does not stop the line driver; only the disable bit does.
	always_comb begin
		n = r;
		n.tx_en = !cfg.tx_disable;
		n.tx_sym = cfg.tx_disable ? `SYM_IDLE : tx_symbol_i;
		n.rx_sym = cfg.loopback ? tx_symbol_i : rx_line_symbol_i;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			r <= PATH_RESET;
		end else begin
			r <= n;
		end
	end

	assign tx_line_symbol_o = r.tx_sym;
	assign tx_line_enable_o = r.tx_en;
	assign rx_symbol_o = r.rx_sym;
endmodule
`default_nettype wire

// >>> t1l_pma_control_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "t1l_pma_defs.svh"
module t1l_pma_regs_checker (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic autoneg_enable_i,
	input wire logic forced_link_config_i,
	input wire logic an_link_master_i,
	input wire logic an_high_amplitude_i,
	input wire logic [`TYPE_W-1:0] an_phy_type_i,
	input wire logic [`SYM_W-1:0] tx_symbol_i,
	input wire logic [`SYM_W-1:0] rx_line_symbol_i,
	input wire logic link_master_o,
	input wire logic [`TYPE_W-1:0] phy_type_o,
	input wire logic phy_type_reserved_o,
	input wire logic transmit_high_amplitude_o,
	input wire logic transmit_output_disable_o,
	input wire logic pma_local_loopback_enable_o,
	input wire logic [`SYM_W-1:0] tx_line_symbol_o,
	input wire logic tx_line_enable_o,
	input wire logic [`SYM_W-1:0] rx_symbol_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// The past-reset guard skips the edge where outputs still hold reset.
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	role_neg_a: assert property (
		$past(rst_n_i) && $past(autoneg_enable_i)
		|-> link_master_o == $past(an_link_master_i))
		else $error("role not from negotiation");
	amp_neg_a: assert property (
		$past(rst_n_i) && $past(autoneg_enable_i)
		|-> transmit_high_amplitude_o == $past(an_high_amplitude_i))
		else $error("amplitude not from negotiation");
	type_neg_a: assert property (
		$past(rst_n_i) && $past(autoneg_enable_i || !forced_link_config_i)
		|-> phy_type_o == $past(an_phy_type_i))
		else $error("type not from negotiation");
	type_rsvd_a: assert property (
		phy_type_reserved_o == (phy_type_o[3] | phy_type_o[2]))
		else $error("reserved type flag wrong");
	tx_enable_a: assert property (
		$past(rst_n_i)
		|-> tx_line_enable_o == !$past(transmit_output_disable_o))
		else $error("line enable wrong");
	tx_suppress_a: assert property (
		$past(rst_n_i) |-> tx_line_symbol_o == ($past(
		transmit_output_disable_o) ? 2'h0 : $past(tx_symbol_i)))
		else $error("line symbol wrong");
	loop_path_a: assert property (
		$past(rst_n_i) |-> rx_symbol_o == ($past(pma_local_loopback_enable_o)
		? $past(tx_symbol_i) : $past(rx_line_symbol_i)))
		else $error("receive symbol wrong");
	cover property (wb_ack_o);
	cover property (pma_local_loopback_enable_o && transmit_output_disable_o);
	cover property (!autoneg_enable_i && forced_link_config_i);
endmodule
bind t1l_pma_control_regs t1l_pma_regs_checker u_chk (.*);
`default_nettype wire

// >>> t1l_pma_control_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "t1l_pma_defs.svh"
module t1l_pma_control_regs_tb_top;
	logic clock_i = 1'b0, rst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [15:0] wb_adr_i = 16'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rdat, d;
	logic wb_ack_o, strap_master_i = 1'b0, strap_high_amplitude_i = 1'b0;
	logic autoneg_enable_i = 1'b0, forced_link_config_i = 1'b0;
	logic an_link_master_i = 1'b0, an_high_amplitude_i = 1'b0;
	logic [3:0] an_phy_type_i = 4'h2, phy_type_o, s;
	logic [1:0] tx_symbol_i = 2'h0, rx_line_symbol_i = 2'h0;
	logic [1:0] tx_line_symbol_o, rx_symbol_o;
	logic link_master_o, phy_type_reserved_o, transmit_high_amplitude_o;
	logic transmit_output_disable_o, energy_efficient_enable_o;
	logic pma_local_loopback_enable_o, tx_line_enable_o;
	logic [15:0] bt1_m, lr_m, a;
	int fail_count = 0, cmp_count = 0;
	t1l_pma_control_regs u_dut (.*);
	initial begin
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		tx_symbol_i <= 2'($urandom);
		rx_line_symbol_i <= 2'($urandom);
	end
	task automatic chk_reg(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_pin(input string n, input logic [3:0] e, g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [15:0] ad,
		input logic [31:0] dt, input logic [3:0] sl);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= dt;
		wb_sel_i <= sl;
		do begin
			@(posedge clock_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rdat = wb_dat_o;
		if (n >= 50) begin
			fail_count++;
			test_done;
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock_i);
	endtask
	function automatic logic [15:0] upd(input logic [15:0] o, m);
		logic [15:0] k;
		k = m & {{8{s[1]}}, {8{s[0]}}};
		return (o & ~k) | (d[15:0] & k);
	endfunction
	task automatic do_reset(input logic m, h);
		rst_n_i <= 1'b0;
		strap_master_i <= m;
		strap_high_amplitude_i <= h;
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		bt1_m = `BT1_CTRL_RESET | {1'b0, m, 14'h0};
		lr_m = {3'b000, h, 12'h000};
	endtask
	task automatic check_all;
		logic [3:0] t;
		logic mr, hr;
		repeat (2) @(posedge clock_i);
		xfer(1'b0, 16'h20d0, 32'h0, 4'hf);
		chk_reg("bt1 control", {16'h0, bt1_m}, rdat);
		xfer(1'b0, 16'h23d8, 32'h0, 4'hf);
		chk_reg("long reach control", {16'h0, lr_m}, rdat);
		chk_pin("role", 4'(autoneg_enable_i ? an_link_master_i
			: bt1_m[14]), 4'(link_master_o));
		chk_pin("amplitude", 4'(autoneg_enable_i ? an_high_amplitude_i
			: lr_m[12]), 4'(transmit_high_amplitude_o));
		chk_pin("type", (!autoneg_enable_i && forced_link_config_i)
			? bt1_m[3:0] : an_phy_type_i, phy_type_o);
		chk_pin("disable", 4'(lr_m[14]),
			4'(transmit_output_disable_o));
		chk_pin("eee", 4'(lr_m[10]), 4'(energy_efficient_enable_o));
		chk_pin("loopback", 4'(lr_m[0]),
			4'(pma_local_loopback_enable_o));
		t = (!autoneg_enable_i && forced_link_config_i) ? bt1_m[3:0]
			: an_phy_type_i;
		mr = autoneg_enable_i ? an_link_master_i : bt1_m[14];
		hr = autoneg_enable_i ? an_high_amplitude_i : lr_m[12];
		xfer(1'b0, 16'h2400, 32'h0, 4'hf);
		chk_reg("status", {22'h0, forced_link_config_i, autoneg_enable_i,
			t, 1'b0, t[3] | t[2], hr, mr}, rdat);
	endtask
	initial begin
		void'($urandom(32'h2f536add));
		for (int i = 0; i < 2; i++) begin
			do_reset(i[0], !i[0]);
			check_all;
			xfer(1'b0, 16'h0004, 32'h0, 4'hf);
			chk_reg("unmapped", 32'h0, rdat);
		end
		// Straps change too: they must be ignored once reset is over.
		for (int i = 0; i < 40; i++) begin
			{autoneg_enable_i, forced_link_config_i, an_link_master_i,
				an_high_amplitude_i, strap_master_i,
				strap_high_amplitude_i} <= 6'($urandom);
			an_phy_type_i <= 4'($urandom);
			d = $urandom;
			d[3:0] = `TYPE_10BASE_T1L;
			s = 4'($urandom);
			a = i[0] ? 16'h20d0 : 16'h23d8;
			xfer(1'b1, a, d, s);
			if (i[0])
				bt1_m = upd(bt1_m, `BT1_CTRL_WMASK);
			else
				lr_m = upd(lr_m, `LR_CTRL_WMASK) & 16'h7fff;
			check_all;
		end
		autoneg_enable_i <= 1'b1;
		for (int c = 0; c < 16; c++) begin
			an_phy_type_i <= 4'(c);
			repeat (2) @(posedge clock_i);
			chk_pin("type code", 4'(c), phy_type_o);
			chk_pin("reserved", 4'(c >= 4), 4'(phy_type_reserved_o));
		end
		test_done;
	end
	initial begin
		#40000;
		fail_count++;
		test_done;
	end
endmodule
`default_nettype wire
